// ---- include/srp_pkg.sv ----
// package of constants for the shared reset pin function select block
package srp_pkg;
  // ---------------------------------------------------------------
  // clocking
  // ---------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ = 125_000_000;
  localparam int unsigned ICG_NOMINAL_HZ = 16_000_000;
  localparam int unsigned BUS_CLK_HZ = 4_000_000;
  localparam int unsigned BUS_DIV = ICG_NOMINAL_HZ / BUS_CLK_HZ;
  localparam int unsigned CORE_PER_BUS = CORE_CLK_HZ / BUS_CLK_HZ;
  localparam int unsigned BUS_DIV_W = 6;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic RST_RESET_FN = 1'b0;
  localparam logic RST_DEBUG_FN = 1'b1;
  localparam logic RST_IRQ_FN = 1'b0;
  localparam logic RST_IRQ_PULL_DIS = 1'b0;
  // ---------------------------------------------------------------
  // pin function of the shared reset-capable pin
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SRP_FN_GPIO = 4'h1,
    SRP_FN_IRQ = 4'h2,
    SRP_FN_CAPT = 4'h4,
    SRP_FN_RESET = 4'h8
  } srp_fn_t;
endpackage

// ---- rtl/srp_pull_cell.sv ----
// pull device control for one general purpose pin
`timescale 1ns/1ps
module srp_pull_cell (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pull_en,
  input wire logic i_drive_out,
  input wire logic i_key_en,
  input wire logic i_key_edge,
  output logic o_pullup,
  output logic o_pulldown
);
  wire pull_on = i_pull_en & ~i_drive_out; // RULE11 RULE17
  wire flip_down = i_key_en & i_key_edge; // RULE10
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pullup <= 1'b0;
      o_pulldown <= 1'b0;
    end else begin
      o_pullup <= pull_on & ~flip_down;
      o_pulldown <= pull_on & flip_down; // RULE10
    end
  end
endmodule

// ---- rtl/srp_pin_select.sv ----
// shared reset pin and debug pin function select with pull control
// What this block does
// RULE1: user mode power-on: shared pin is input
// RULE2: reset enable bit turns pin to reset
// RULE3: reset function sticks until next power-on
// RULE4: low on reset pin resets whole chip
// RULE5: reset function forces internal pullup on
// RULE6: debug power-on: shared pin is reset
// RULE7: timer capture mode routes pin to capture
// RULE8: irq function gives selectable pull device
// RULE9: debug function enables debug pin pullup
// RULE10: key edge select turns pullup into pulldown
// RULE11: each input pin has own pullup enable
// RULE12: registers clock on bus clock enable
// RULE13: bus clock is 4 MHz from 16; the enable here divides the 125 MHz core clock by 31 instead
// RULE14: reset pin never enters debug mode
// RULE15: mode pin low at power-on forces debug
// RULE16: debug enable set after every reset
// RULE17: driven output disables pin pullup
`timescale 1ns/1ps
module srp_pin_select
  import srp_pkg::*;
#(
  parameter int unsigned N_GPIO = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por,
  input wire logic i_opt_wr,
  input wire logic i_reset_pin_fn_enable,
  input wire logic i_irq_pin_fn_enable,
  input wire logic i_irq_pull_disable,
  input wire logic i_irq_rising,
  input wire logic i_debug_pin_fn_enable,
  input wire logic i_force_wr,
  input wire logic i_debug_force_reset_bit,
  input wire logic i_timer2_capture_mode,
  input wire logic i_shared_pin,
  input wire logic i_mode_select_pin,
  input wire logic i_debug_pin_drive,
  input wire logic [N_GPIO-1:0] i_gpio_pull_en,
  input wire logic [N_GPIO-1:0] i_gpio_drive_out,
  input wire logic [N_GPIO-1:0] i_key_pin_enable,
  input wire logic [N_GPIO-1:0] i_key_edge_select,
  output logic o_bus_clk_en,
  output logic o_chip_reset,
  output logic o_debug_halt_mode,
  output logic o_reset_fn_active,
  output logic o_debug_fn_active,
  output logic o_irq_fn_active,
  output logic [3:0] o_shared_fn,
  output logic o_port_a_bit5,
  output logic o_irq_in,
  output logic o_timer2_capture_in,
  output logic o_shared_pullup,
  output logic o_shared_pulldown,
  output logic o_debug_pullup,
  output logic [N_GPIO-1:0] o_gpio_pullup,
  output logic [N_GPIO-1:0] o_gpio_pulldown
);
  // ---------------------------------------------------------------
  // bus clock enable divider
  // ---------------------------------------------------------------
  localparam logic [BUS_DIV_W-1:0] DIV_LAST = BUS_DIV_W'(CORE_PER_BUS - 1);
  logic [BUS_DIV_W-1:0] div_r;
  wire div_wrap = (div_r == DIV_LAST);
  wire bus_tick = div_wrap; // RULE13
  always_ff @(posedge i_clk) begin
    if (i_rst | i_por) begin
      div_r <= '0;
      o_bus_clk_en <= 1'b0;
    end else begin
      div_r <= div_wrap ? '0 : div_r + 1'b1;
      o_bus_clk_en <= bus_tick;
    end
  end

  // ---------------------------------------------------------------
  // option bits
  // ---------------------------------------------------------------
  logic reset_fn_r;
  logic debug_fn_r;
  logic irq_fn_r;
  logic irq_pull_dis_r;
  logic debug_mode_r;
  logic por_seen_r;
  logic force_pend_r;
  wire opt_take = i_opt_wr & bus_tick; // RULE12
  // set only, cleared by power-on alone
  wire reset_fn_nxt = reset_fn_r | (opt_take & i_reset_pin_fn_enable); // RULE2 RULE3
  wire force_take = i_force_wr & bus_tick & i_debug_force_reset_bit;
  always_ff @(posedge i_clk) begin
    if (i_por) begin
      reset_fn_r <= RST_RESET_FN; // RULE1
      debug_fn_r <= RST_DEBUG_FN;
      irq_fn_r <= RST_IRQ_FN;
      irq_pull_dis_r <= RST_IRQ_PULL_DIS;
      debug_mode_r <= 1'b0;
      por_seen_r <= 1'b1;
      force_pend_r <= 1'b0;
    end else if (i_rst | o_chip_reset) begin
      debug_fn_r <= RST_DEBUG_FN; // RULE16
      irq_fn_r <= RST_IRQ_FN;
      irq_pull_dis_r <= RST_IRQ_PULL_DIS;
      por_seen_r <= 1'b0;
      force_pend_r <= 1'b0;
      // pin reset goes to user mode only
      if (o_chip_reset & ~force_pend_r)
        debug_mode_r <= 1'b0; // RULE14
      else if (force_pend_r)
        debug_mode_r <= ~i_mode_select_pin; // RULE15
    end else begin
      reset_fn_r <= reset_fn_nxt;
      if (por_seen_r) begin
        // first cycle out of power-on: sample mode select
        debug_mode_r <= ~i_mode_select_pin; // RULE15
        reset_fn_r <= ~i_mode_select_pin | reset_fn_r; // RULE6
        por_seen_r <= 1'b0;
      end
      if (opt_take) begin
        debug_fn_r <= i_debug_pin_fn_enable;
        irq_fn_r <= i_irq_pin_fn_enable;
        irq_pull_dis_r <= i_irq_pull_disable;
      end
      if (force_take)
        force_pend_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // shared pin function decode, reset highest
  // ---------------------------------------------------------------
  srp_fn_t fn_sel;
  assign fn_sel = reset_fn_r ? SRP_FN_RESET :
                  i_timer2_capture_mode ? SRP_FN_CAPT : // RULE7
                  irq_fn_r ? SRP_FN_IRQ : SRP_FN_GPIO; // RULE1
  wire pin_reset = (fn_sel == SRP_FN_RESET) & ~i_shared_pin; // RULE4
  wire irq_pull_on = irq_fn_r & ~irq_pull_dis_r & ~reset_fn_r; // RULE8

  always_ff @(posedge i_clk) begin
    if (i_rst | i_por) begin
      o_chip_reset <= 1'b0;
      o_debug_halt_mode <= 1'b0;
      o_reset_fn_active <= 1'b0;
      o_debug_fn_active <= 1'b0;
      o_irq_fn_active <= 1'b0;
      o_shared_fn <= SRP_FN_GPIO;
      o_port_a_bit5 <= 1'b0;
      o_irq_in <= 1'b0;
      o_timer2_capture_in <= 1'b0;
      o_shared_pullup <= 1'b0;
      o_shared_pulldown <= 1'b0;
      o_debug_pullup <= 1'b0;
    end else begin
      // a forced reset is a single cycle pulse, so its tail cannot clear the mode it set
      o_chip_reset <= pin_reset | (force_pend_r & ~o_chip_reset); // RULE4
      o_debug_halt_mode <= debug_mode_r;
      o_reset_fn_active <= reset_fn_r;
      o_debug_fn_active <= debug_fn_r;
      o_irq_fn_active <= irq_fn_r;
      o_shared_fn <= fn_sel;
      o_port_a_bit5 <= (fn_sel == SRP_FN_GPIO) & i_shared_pin;
      o_irq_in <= (fn_sel == SRP_FN_IRQ) & i_shared_pin;
      o_timer2_capture_in <= (fn_sel == SRP_FN_CAPT) & i_shared_pin; // RULE7
      o_shared_pullup <= reset_fn_r | (irq_pull_on & ~i_irq_rising); // RULE5 RULE8
      o_shared_pulldown <= irq_pull_on & i_irq_rising; // RULE8
      o_debug_pullup <= debug_fn_r & ~i_debug_pin_drive; // RULE9 RULE17
    end
  end

  // ---------------------------------------------------------------
  // per pin pull devices of the general purpose port
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_GPIO; g++) begin : g_pull
      srp_pull_cell u_cell (
        .i_clk(i_clk),
        .i_rst(i_rst | i_por),
        .i_pull_en(i_gpio_pull_en[g]),
        .i_drive_out(i_gpio_drive_out[g]),
        .i_key_en(i_key_pin_enable[g]),
        .i_key_edge(i_key_edge_select[g]),
        .o_pullup(o_gpio_pullup[g]),
        .o_pulldown(o_gpio_pulldown[g])
      );
    end
  endgenerate
endmodule

// ---- testbench/srp_pin_select_sva.sv ----
// assertions on the pin select ports
`timescale 1ns/1ps
module srp_pin_select_sva
  import srp_pkg::*;
#(parameter int unsigned N_GPIO = 4) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por,
  input wire logic i_shared_pin,
  input wire logic i_debug_pin_drive,
  input wire logic [N_GPIO-1:0] i_gpio_drive_out,
  input wire logic o_bus_clk_en,
  input wire logic o_chip_reset,
  input wire logic o_reset_fn_active,
  input wire logic o_debug_fn_active,
  input wire logic [3:0] o_shared_fn,
  input wire logic o_shared_pullup,
  input wire logic o_debug_pullup,
  input wire logic [N_GPIO-1:0] o_gpio_pullup
);
  logic live_r;
  always_ff @(posedge i_clk) live_r <= !(i_rst || i_por);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst || i_por);
  a_fn_one_hot: assert property ($onehot(o_shared_fn)) else $error("function not one-hot");
  a_reset_fn_wins: assert property (o_reset_fn_active && $past(o_reset_fn_active) |->
    o_shared_fn == SRP_FN_RESET) else $error("reset function not selected");
  a_reset_fn_sticks: assert property (o_reset_fn_active |=> o_reset_fn_active)
    else $error("reset function dropped");
  a_pin_low_resets: assert property (o_reset_fn_active && !i_shared_pin |=> o_chip_reset)
    else $error("pin low gave no chip reset");
  a_reset_pullup_on: assert property (o_reset_fn_active && $past(o_reset_fn_active) |-> o_shared_pullup)
    else $error("reset pin pullup off");
  a_debug_pullup_on: assert property (live_r && o_debug_fn_active && $past(o_debug_fn_active) &&
    !$past(i_debug_pin_drive) |-> o_debug_pullup) else $error("debug pullup off");
  a_drive_kills_pull: assert property (live_r && $past(i_gpio_drive_out[0]) |-> !o_gpio_pullup[0])
    else $error("pullup on driven pin");
  a_bus_tick_period: assert property (o_bus_clk_en |=> !o_bus_clk_en ##30 o_bus_clk_en)
    else $error("bus tick period wrong");
endmodule
bind srp_pin_select srp_pin_select_sva #(.N_GPIO(N_GPIO)) srp_pin_select_sva_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_por(i_por), .i_shared_pin(i_shared_pin),
  .i_debug_pin_drive(i_debug_pin_drive), .i_gpio_drive_out(i_gpio_drive_out), .o_bus_clk_en(o_bus_clk_en),
  .o_chip_reset(o_chip_reset), .o_reset_fn_active(o_reset_fn_active), .o_debug_fn_active(o_debug_fn_active),
  .o_shared_fn(o_shared_fn), .o_shared_pullup(o_shared_pullup), .o_debug_pullup(o_debug_pullup),
  .o_gpio_pullup(o_gpio_pullup));

// ---- testbench/srp_pin_partner.sv ----
// model of the external reset source and debug adapter
`timescale 1ns/1ps
module srp_pin_partner (
  input wire logic i_pull_reset,
  input wire logic i_hold_mode,
  output logic o_shared_pin,
  output logic o_mode_select_pin
);
  // released lines rest at the pullup level
  assign o_shared_pin = !i_pull_reset;
  assign o_mode_select_pin = !i_hold_mode;
endmodule

// ---- testbench/test_srp_pin_select.sv ----
// testbench for the shared reset pin function select
`timescale 1ns/1ps
module test_srp_pin_select;
  import srp_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_por = 1'b1, i_opt_wr = 1'b0, i_force_wr = 1'b0, i_force_bit = 1'b0;
  logic i_irq_rising = 1'b0, i_cap = 1'b0, pull_reset = 1'b0, hold_mode = 1'b0, dbg_drv = 1'b0;
  logic [3:0] opt = 4'h0, pe = 4'h0, dr = 4'h0, ke = 4'h0, ks = 4'h0;
  logic shared_pin, mode_pin, bus_en, chip_rst, dbg_halt, rst_fn, dbg_fn, port5, cap_in, shr_up, shr_dn, dbg_up;
  logic irq_act, irq_in;
  logic [3:0] fn, gup, gdn;
  logic [7:0] tbl [3] = '{8'h55, 8'h5b, 8'h68};
  int errors = 0, total_checks = 0, rst_cnt = 0;
  always #4 i_clk = ~i_clk;
  always @(negedge i_clk) if (chip_rst) rst_cnt <= rst_cnt + 1;
  srp_pin_partner srp_pin_partner_inst (.i_pull_reset(pull_reset), .i_hold_mode(hold_mode),
    .o_shared_pin(shared_pin), .o_mode_select_pin(mode_pin));
  srp_pin_select #(.N_GPIO(4)) srp_pin_select_inst (.i_clk(i_clk), .i_rst(i_rst), .i_por(i_por),
    .i_opt_wr(i_opt_wr), .i_reset_pin_fn_enable(opt[3]), .i_irq_pin_fn_enable(opt[2]),
    .i_irq_pull_disable(opt[1]), .i_irq_rising(i_irq_rising), .i_debug_pin_fn_enable(opt[0]),
    .i_force_wr(i_force_wr), .i_debug_force_reset_bit(i_force_bit), .i_timer2_capture_mode(i_cap),
    .i_shared_pin(shared_pin), .i_mode_select_pin(mode_pin), .i_debug_pin_drive(dbg_drv), .i_gpio_pull_en(pe),
    .i_gpio_drive_out(dr), .i_key_pin_enable(ke), .i_key_edge_select(ks), .o_bus_clk_en(bus_en),
    .o_chip_reset(chip_rst), .o_debug_halt_mode(dbg_halt), .o_reset_fn_active(rst_fn), .o_debug_fn_active(dbg_fn),
    .o_irq_fn_active(irq_act), .o_shared_fn(fn), .o_port_a_bit5(port5), .o_irq_in(irq_in),
    .o_timer2_capture_in(cap_in),
    .o_shared_pullup(shr_up), .o_shared_pulldown(shr_dn), .o_debug_pullup(dbg_up), .o_gpio_pullup(gup),
    .o_gpio_pulldown(gdn));
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // write is held until a bus tick has taken it
  task automatic wr(input logic frc);
    int k;
    k = 0;
    {i_force_wr, i_opt_wr} = frc ? 2'b10 : 2'b01;
    do begin
      @(negedge i_clk);
      k++;
    end while (!bus_en && k < 100);
    if (!bus_en) errors++;
    {i_force_wr, i_opt_wr} = 2'b00;
    cyc(4);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #40000;
    errors++;
    tally_and_finish;
  end
  initial begin
    int n, base;
    cyc(8);
    {i_rst, i_por} = 2'b00;
    cyc(3);
    chk(fn, SRP_FN_GPIO);
    chk({rst_fn, dbg_fn, dbg_up, port5}, 4'h7);
    n = 0;
    while (!bus_en) cyc(1);
    do begin
      cyc(1);
      n++;
    end while (!bus_en && n < 100);
    chk(4'(n >> 4), 4'(CORE_PER_BUS >> 4));
    chk(4'(n), 4'(CORE_PER_BUS));
    {pe, dr, ke, ks} = 16'hf122;
    dbg_drv = 1'b1;
    cyc(2);
    chk(gup, 4'hc);
    chk(gdn, 4'h2);
    chk(dbg_up, 4'h0);
    dbg_drv = 1'b0;
    i_cap = 1'b1;
    cyc(2);
    chk(fn, SRP_FN_CAPT);
    chk(cap_in, 4'h1);
    i_cap = 1'b0;
    foreach (tbl[i]) begin
      opt = tbl[i][7:4];
      i_irq_rising = tbl[i][3];
      wr(1'b0);
      chk(fn, SRP_FN_IRQ);
      chk({irq_act, irq_in}, 4'h3);
      chk({shr_up, shr_dn, dbg_up}, tbl[i][2:0]);
    end
    opt = 4'h8;
    wr(1'b0);
    chk(fn, SRP_FN_RESET);
    chk({rst_fn, shr_up, shr_dn}, 4'h6);
    opt = 4'h0;
    wr(1'b0);
    chk(rst_fn, 4'h1);
    pull_reset = 1'b1;
    cyc(2);
    chk({chip_rst, dbg_halt}, 4'h2);
    pull_reset = 1'b0;
    i_rst = 1'b1;
    cyc(2);
    i_rst = 1'b0;
    cyc(3);
    chk({rst_fn, dbg_fn}, 4'h3);
    hold_mode = 1'b1;
    i_por = 1'b1;
    cyc(8);
    i_por = 1'b0;
    cyc(3);
    chk({dbg_halt, rst_fn}, 4'h3);
    i_force_bit = 1'b1;
    for (int m = 0; m < 2; m++) begin
      hold_mode = m[0];
      base = rst_cnt;
      wr(1'b1);
      chk(4'(rst_cnt - base), 4'h1);
      chk({3'h0, dbg_halt}, {3'h0, m[0]});
    end
    pull_reset = 1'b1;
    cyc(3);
    chk({chip_rst, dbg_halt}, 4'h2);
    pull_reset = 1'b0;
    tally_and_finish;
  end
endmodule
